// *** verilog/sdse_defines.vh ***
// Purpose: constants for the safety relay status encoder
// Assumes: included by the encoder module only
// Notes: bit positions are counted from 0 inside each byte, from 1 inside the frame
`ifndef SDSE_DEFINES_VH
`define SDSE_DEFINES_VH
// -----------------------------------------------------------------
// serial diagnostic frame (frame bit k sits at vector index k-1)
// -----------------------------------------------------------------
`define SDSE_FRAME_BITS 20
`define SDSE_FB_CIRC1 0
`define SDSE_FB_CIRC2 1
`define SDSE_FB_RELAYS 2
`define SDSE_FB_ACK 3
`define SDSE_FB_SW0 4
`define SDSE_FRAME_SW 16
// -----------------------------------------------------------------
// process data byte 0 fields
// -----------------------------------------------------------------
`define SDSE_PB_CIRC1 0
`define SDSE_PB_CIRC2 1
`define SDSE_PB_RELAYS 2
`define SDSE_PB_ACK 3
`define SDSE_PB_CODE_LO 4
// -----------------------------------------------------------------
// status and error codes
// -----------------------------------------------------------------
`define SDSE_CODE_SYSTEM 4'h7
`define SDSE_CODE_INPUT 4'h6
`define SDSE_CODE_LINK_UV 4'h5
`define SDSE_CODE_RELAY_UV 4'h4
`define SDSE_CODE_COMM 4'h3
`define SDSE_CODE_PARAM 4'h2
`define SDSE_CODE_DIAG 4'h1
`define SDSE_CODE_ACTIVE 4'h0
// -----------------------------------------------------------------
// process data lengths
// -----------------------------------------------------------------
`define SDSE_LEN_A 8'h06
`define SDSE_LEN_B 8'h0B
`define SDSE_LEN_C 8'h15
`define SDSE_LEN_D 8'h1F
`define SDSE_CHAIN_A 8'h05
`define SDSE_CHAIN_B 8'h0A
`define SDSE_CHAIN_C 8'h14
`define SDSE_OUT_LEN 8'h01
`define SDSE_OUT_ENABLE 0
`define SDSE_OUT_CHAIN_RST 1
// -----------------------------------------------------------------
// synchroniser slots for the single-bit pins
// -----------------------------------------------------------------
`define SDSE_SY_CIRC1 0
`define SDSE_SY_CIRC2 1
`define SDSE_SY_RELAY1 2
`define SDSE_SY_RELAY2 3
`define SDSE_SY_ACK 4
`define SDSE_SY_SYSTEM 5
`define SDSE_SY_INPUT 6
`define SDSE_SY_LINK_UV 7
`define SDSE_SY_RELAY_UV 8
`define SDSE_SY_COMM 9
`define SDSE_SY_PARAM 10
`define SDSE_SY_DIAG 11
`define SDSE_SY_PINS 12
// switch byte bits passed on: all but the two spare ones
`define SDSE_SW_USED_MASK 8'hE7
`endif

// *** verilog/sdse_encoder.v ***
// Purpose: encode relay status as serial diagnostic frame and process image
// Assumes: status pins asynchronous, switch status bytes and chain count synchronous; one clock CORE_CLK, sync reset RST
// Notes: the process image is streamed byte by byte through a two-entry buffer
//
// Behaviour
// - serial output driven inverted: one means low
// - frame bits 1,2 show sensor circuits active
// - frame bit 3 relays, bit 4 acknowledgment
// - frame bits 5-20 show switches 1-16 closed
// - byte 0 bits 0,1 show sensor circuits
// - byte 0 bit 2 shows both relays active
// - byte 0 bit 3 shows acknowledgment required
// - byte 0 bits 4-7 carry status code
// - only highest priority pending code reported
// - code 0000 always pending as fallback
// - 0111 system error, 0110 input error
// - 0101 link undervoltage, 0100 relay undervoltage
// - 0011 when switches unreachable
// - 0010 wrong maker code or size short
// - 0001 diagnostics active
// - input length 6/11/21/31, output one byte
// - byte 0 relay, byte n switch n
// - switch byte: detect, limit, ack, errors 5-7
`timescale 1ns/1ps
`include "sdse_defines.vh"
module sdse_encoder #(
   parameter MAX_SW = 30
) (
   // clock and reset
   CORE_CLK,
   RST,
   // relay status pins
   FIRST_SENSOR_CIRCUIT,
   SECOND_SENSOR_CIRCUIT,
   FIRST_OUTPUT_RELAY,
   SECOND_OUTPUT_RELAY,
   START_ACK_REQ,
   // error condition pins
   ERR_SYSTEM,
   ERR_INPUT,
   ERR_LINK_UV,
   ERR_RELAY_UV,
   ERR_COMM,
   ERR_PARAM,
   ERR_DIAG,
   // chained switch status
   SWITCH_CLOSED,
   SWITCH_STATUS,
   CHAIN_COUNT,
   // serial diagnostics
   DIAGNOSTIC_SIGNAL_OUTPUT,
   FRAME_STATUS,
   // process image request and stream
   CYCLE_START,
   PD_DATA,
   PD_INDEX,
   PD_LAST,
   PD_VALID,
   PD_READY,
   PD_IN_LEN,
   PD_OUT_LEN,
   // output process data from master
   OUT_BYTE,
   ENABLE_PATHS,
   CHAIN_RESET
);
   // clock and reset
   input wire CORE_CLK;
   input wire RST;
   // relay status pins
   input wire FIRST_SENSOR_CIRCUIT;
   input wire SECOND_SENSOR_CIRCUIT;
   input wire FIRST_OUTPUT_RELAY;
   input wire SECOND_OUTPUT_RELAY;
   input wire START_ACK_REQ;
   // error condition pins
   input wire ERR_SYSTEM;
   input wire ERR_INPUT;
   input wire ERR_LINK_UV;
   input wire ERR_RELAY_UV;
   input wire ERR_COMM;
   input wire ERR_PARAM;
   input wire ERR_DIAG;
   // chained switch status
   input wire [`SDSE_FRAME_SW-1:0] SWITCH_CLOSED;
   input wire [8*MAX_SW-1:0] SWITCH_STATUS;
   input wire [7:0] CHAIN_COUNT;
   // serial diagnostics
   output reg DIAGNOSTIC_SIGNAL_OUTPUT;
   output reg [`SDSE_FRAME_BITS-1:0] FRAME_STATUS;
   // process image request and stream
   input wire CYCLE_START;
   output reg [7:0] PD_DATA;
   output reg [7:0] PD_INDEX;
   output reg PD_LAST;
   output reg PD_VALID;
   input wire PD_READY;
   output reg [7:0] PD_IN_LEN;
   output reg [7:0] PD_OUT_LEN;
   // output process data from master
   input wire [7:0] OUT_BYTE;
   output reg ENABLE_PATHS;
   output reg CHAIN_RESET;

   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   // every level pin lands in one slot of a shared two-flop chain; the slot
   // map lives in the defines header so the encoder and the frame agree
   // a pin that flips near an edge may show a cycle late, never half-set,
   // because the pins are independent flags rather than one coded word
   localparam NSYNC = `SDSE_SY_PINS + `SDSE_FRAME_SW;
   wire [NSYNC-1:0] raw_in;
   reg [NSYNC-1:0] meta_reg;
   reg [NSYNC-1:0] sync_reg;
   assign raw_in = {SWITCH_CLOSED, ERR_DIAG, ERR_PARAM, ERR_COMM, ERR_RELAY_UV,
                    ERR_LINK_UV, ERR_INPUT, ERR_SYSTEM, START_ACK_REQ,
                    SECOND_OUTPUT_RELAY, FIRST_OUTPUT_RELAY,
                    SECOND_SENSOR_CIRCUIT, FIRST_SENSOR_CIRCUIT};
   // two flops on every pin; only the second stage is read
   always @(posedge CORE_CLK) begin
      if (RST) begin
         meta_reg <= {NSYNC{1'b0}};
         sync_reg <= {NSYNC{1'b0}};
      end else begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
      end
   end
   wire circ1 = sync_reg[`SDSE_SY_CIRC1];
   wire circ2 = sync_reg[`SDSE_SY_CIRC2];
   wire relays = sync_reg[`SDSE_SY_RELAY1] & sync_reg[`SDSE_SY_RELAY2];
   wire ack = sync_reg[`SDSE_SY_ACK];
   wire [`SDSE_FRAME_SW-1:0] sw_closed = sync_reg[NSYNC-1:`SDSE_SY_PINS];

   // -----------------------------------------------------------------
   // priority encoder for status code
   // -----------------------------------------------------------------
   reg [3:0] code;
   // scan from the largest code down, so the first hit suppresses the rest
   always @* begin
      if (sync_reg[`SDSE_SY_SYSTEM])
         code = `SDSE_CODE_SYSTEM;
      else if (sync_reg[`SDSE_SY_INPUT])
         code = `SDSE_CODE_INPUT;
      else if (sync_reg[`SDSE_SY_LINK_UV])
         code = `SDSE_CODE_LINK_UV;
      else if (sync_reg[`SDSE_SY_RELAY_UV])
         code = `SDSE_CODE_RELAY_UV;
      else if (sync_reg[`SDSE_SY_COMM])
         code = `SDSE_CODE_COMM;
      else if (sync_reg[`SDSE_SY_PARAM])
         code = `SDSE_CODE_PARAM;
      else if (sync_reg[`SDSE_SY_DIAG])
         code = `SDSE_CODE_DIAG;
      else
         code = `SDSE_CODE_ACTIVE;
   end

   // -----------------------------------------------------------------
   // relay status byte and serial frame
   // -----------------------------------------------------------------
   wire [7:0] status_byte;
   assign status_byte = {code, ack, relays, circ2, circ1};
   wire [`SDSE_FRAME_BITS-1:0] frame_next;
   assign frame_next = {sw_closed, ack, relays, circ2, circ1};

   // serial bit shifted out continuously; level is the inverse of the bit
   // each pass sends the snapshot taken at its first bit, so a pin that
   // moves in mid-pass cannot tear the frame the evaluator receives
   reg [4:0] bit_reg;
   always @(posedge CORE_CLK) begin
      if (RST) begin
         bit_reg <= 5'h00;
         FRAME_STATUS <= {`SDSE_FRAME_BITS{1'b0}};
         DIAGNOSTIC_SIGNAL_OUTPUT <= 1'b1;
      end else begin
         bit_reg <= (bit_reg == `SDSE_FRAME_BITS - 1) ? 5'h00 : bit_reg + 5'h01;
         if (bit_reg == 5'h00) begin
            FRAME_STATUS <= frame_next; // frame latched once per pass
            DIAGNOSTIC_SIGNAL_OUTPUT <= ~frame_next[`SDSE_FB_CIRC1];
         end else begin
            DIAGNOSTIC_SIGNAL_OUTPUT <= ~FRAME_STATUS[bit_reg];
         end
      end
   end

   // -----------------------------------------------------------------
   // process data length from chain size
   // -----------------------------------------------------------------
   // the master reads these lengths to size its image; the input length follows the chain, the output length stays one byte
   always @(posedge CORE_CLK) begin
      if (RST) begin
         PD_IN_LEN <= `SDSE_LEN_A;
         PD_OUT_LEN <= `SDSE_OUT_LEN;
      end else begin
         PD_OUT_LEN <= `SDSE_OUT_LEN;
         if (CHAIN_COUNT <= `SDSE_CHAIN_A)
            PD_IN_LEN <= `SDSE_LEN_A;
         else if (CHAIN_COUNT <= `SDSE_CHAIN_B)
            PD_IN_LEN <= `SDSE_LEN_B;
         else if (CHAIN_COUNT <= `SDSE_CHAIN_C)
            PD_IN_LEN <= `SDSE_LEN_C;
         else
            PD_IN_LEN <= `SDSE_LEN_D;
      end
   end

   // -----------------------------------------------------------------
   // master output byte: enable and chain reset on falling bit 1
   // -----------------------------------------------------------------
   reg prev_rst_bit_reg;
   always @(posedge CORE_CLK) begin
      if (RST) begin
         ENABLE_PATHS <= 1'b0;
         CHAIN_RESET <= 1'b0;
         prev_rst_bit_reg <= 1'b0;
      end else begin
         ENABLE_PATHS <= OUT_BYTE[`SDSE_OUT_ENABLE];
         prev_rst_bit_reg <= OUT_BYTE[`SDSE_OUT_CHAIN_RST];
         CHAIN_RESET <= prev_rst_bit_reg & ~OUT_BYTE[`SDSE_OUT_CHAIN_RST];
      end
   end

   // -----------------------------------------------------------------
   // byte producer: byte 0 relay, byte n switch n
   // -----------------------------------------------------------------
   // the length is frozen at the start of a cycle so a chain count that
   // moves mid-transfer cannot cut the image short or stretch it
   reg busy_reg;
   reg [7:0] idx_reg;
   reg [7:0] len_reg;
   reg [7:0] src_byte;
   wire push;
   wire buf_ready;
   assign push = busy_reg & buf_ready;
   // switch bytes pass with the two spare bits cleared: detect, limit, ack, two spare, three errors
   always @* begin
      if (idx_reg == 8'h00)
         src_byte = status_byte;
      else if (idx_reg <= MAX_SW)
         src_byte = SWITCH_STATUS[8*(idx_reg-8'h01) +: 8] & `SDSE_SW_USED_MASK;
      else
         src_byte = 8'h00;
   end
   // producer stalls while the buffer is full, so no byte is lost
   always @(posedge CORE_CLK) begin
      if (RST) begin
         busy_reg <= 1'b0;
         idx_reg <= 8'h00;
         len_reg <= `SDSE_LEN_A;
      end else if (!busy_reg) begin
         if (CYCLE_START) begin
            busy_reg <= 1'b1;
            idx_reg <= 8'h00;
            len_reg <= PD_IN_LEN;
         end
      end else if (push) begin
         idx_reg <= idx_reg + 8'h01;
         if (idx_reg == len_reg - 8'h01)
            busy_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // two-entry buffer, output side straight from flops
   // -----------------------------------------------------------------
   // the output flops are the first entry, the skid flop the second; the
   // skid only fills when the receiver stalls while a byte is being pushed
   reg [16:0] skid_reg;
   reg skid_v_reg;
   wire [16:0] in_word;
   assign in_word = {idx_reg == len_reg - 8'h01, idx_reg, src_byte};
   assign buf_ready = ~skid_v_reg;
   wire out_take = ~PD_VALID | PD_READY;
   always @(posedge CORE_CLK) begin
      if (RST) begin
         PD_VALID <= 1'b0;
         PD_DATA <= 8'h00;
         PD_INDEX <= 8'h00;
         PD_LAST <= 1'b0;
         skid_reg <= 17'h00000;
         skid_v_reg <= 1'b0;
      end else if (out_take) begin
         if (skid_v_reg) begin
            {PD_LAST, PD_INDEX, PD_DATA} <= skid_reg;
            PD_VALID <= 1'b1;
            skid_v_reg <= 1'b0;
         end else begin
            {PD_LAST, PD_INDEX, PD_DATA} <= in_word;
            PD_VALID <= push;
         end
      end else if (push) begin
         skid_reg <= in_word;
         skid_v_reg <= 1'b1;
      end
   end
endmodule // sdse_encoder

// *** testbench/sdse_encoder_asserts.sv ***
// Purpose: port-level checks for the status encoder
// Assumes: one clock, sync reset
// Notes: bound to every sdse_encoder instance
`timescale 1ns/1ps
module sdse_encoder_asserts (
   // clock and reset
   input wire CORE_CLK,
   input wire RST,
   // image stream
   input wire [7:0] PD_DATA,
   input wire [7:0] PD_INDEX,
   input wire PD_LAST,
   input wire PD_VALID,
   input wire PD_READY,
   input wire [7:0] PD_IN_LEN,
   input wire [7:0] PD_OUT_LEN,
   input wire [7:0] CHAIN_COUNT,
   // master output byte
   input wire [7:0] OUT_BYTE,
   input wire ENABLE_PATHS,
   input wire CHAIN_RESET
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   reg [7:0] exp_idx;
   // next index the stream owes; restarts after the final byte
   always @(posedge CORE_CLK) begin
      if (RST) exp_idx <= 8'h00;
      else if (PD_VALID && PD_READY) exp_idx <= PD_LAST ? 8'h00 : PD_INDEX + 8'h01;
   end
   function automatic [7:0] len_of(input [7:0] c);
      len_of = c <= 8'h05 ? 8'h06 : c <= 8'h0A ? 8'h0B : c <= 8'h14 ? 8'h15 : 8'h1F;
   endfunction
   pd_hold_a: assert property (PD_VALID && !PD_READY |=> PD_VALID && $stable(PD_DATA)
      && $stable(PD_INDEX) && $stable(PD_LAST)) else $error("byte moved while stalled");
   out_len_a: assert property (PD_OUT_LEN == 8'h01) else $error("output length");
   len_map_a: assert property (PD_VALID && PD_LAST |-> PD_IN_LEN == len_of(CHAIN_COUNT))
      else $error("input length");
   last_idx_a: assert property (PD_VALID && PD_LAST |-> PD_INDEX == PD_IN_LEN - 8'h01)
      else $error("final index");
   idx_order_a: assert property (PD_VALID |-> PD_INDEX == exp_idx)
      else $error("byte order");
   sw_unused_a: assert property (PD_VALID && PD_INDEX != 8'h00 |-> PD_DATA[4:3] == 2'h0)
      else $error("unused bits set");
   enable_follow_a: assert property (!$past(RST) |-> ENABLE_PATHS == $past(OUT_BYTE[0]))
      else $error("enable not following");
   chain_rst_a: assert property ($fell(OUT_BYTE[1]) && !$past(RST) |=> CHAIN_RESET)
      else $error("chain reset missed");
   chain_pulse_a: assert property (CHAIN_RESET |-> $past(OUT_BYTE[1], 2)
      && !$past(OUT_BYTE[1])) else $error("spurious chain reset");
   cover property (PD_VALID && PD_READY && PD_LAST);
   cover property (PD_VALID && !PD_READY);
   cover property (CHAIN_RESET);
endmodule // sdse_encoder_asserts
bind sdse_encoder sdse_encoder_asserts chk_u (.CORE_CLK(CORE_CLK), .RST(RST),
   .PD_DATA(PD_DATA), .PD_INDEX(PD_INDEX), .PD_LAST(PD_LAST), .PD_VALID(PD_VALID),
   .PD_READY(PD_READY), .PD_IN_LEN(PD_IN_LEN), .PD_OUT_LEN(PD_OUT_LEN),
   .CHAIN_COUNT(CHAIN_COUNT), .OUT_BYTE(OUT_BYTE), .ENABLE_PATHS(ENABLE_PATHS),
   .CHAIN_RESET(CHAIN_RESET));

// *** testbench/sdse_link_master.sv ***
// Purpose: link master taking the process image
// Assumes: same clock as the encoder
// Notes: stall makes ready random, to exercise the buffer
`timescale 1ns/1ps
module sdse_link_master (
   // clock and reset
   input wire CORE_CLK,
   input wire RST,
   // image stream
   input wire [7:0] PD_DATA,
   input wire PD_LAST,
   input wire PD_VALID,
   output reg PD_READY,
   // bench control
   input wire stall,
   input wire clear
);
   reg [7:0] rx_mem [0:31];
   reg [7:0] rx_cnt = 8'h00;
   reg rx_done = 1'b0;
   // store bytes in arrival order so a wrong order shows up
   always @(posedge CORE_CLK) begin
      PD_READY <= !RST && (!stall || $urandom_range(1, 0) == 1);
      if (clear) begin
         rx_cnt <= 8'h00;
         rx_done <= 1'b0;
      end else if (PD_VALID && PD_READY && !rx_done) begin
         rx_mem[rx_cnt[4:0]] <= PD_DATA;
         rx_cnt <= rx_cnt + 8'h01;
         rx_done <= PD_LAST;
      end
   end
endmodule // sdse_link_master

// *** testbench/tb_safety_relay_diag_status_encoder.sv ***
// Purpose: random and corner test of the status encoder
// Assumes: 50 MHz clock, two-cycle reset
// Notes: inputs held while the image and serial frame are checked
`timescale 1ns/1ps
module tb_safety_relay_diag_status_encoder;
   localparam [71:0] CORNER = {8'h1E, 8'h15, 8'h14, 8'h0B, 8'h0A, 8'h06, 8'h05, 8'h01, 8'h00};
   reg clk = 1'b0, rst = 1'b1, c1 = 1'b0, c2 = 1'b0, k1 = 1'b0, k2 = 1'b0, ack = 1'b0;
   reg cs = 1'b0, stall = 1'b0, clear = 1'b0, hit;
   reg [6:0] errs = 7'h00;
   reg [15:0] sw_cl = 16'h0000;
   reg [255:0] st_w = 256'h0;
   reg [7:0] cc = 8'h00, ob = 8'h00, len;
   reg [19:0] s, fexp;
   reg [39:0] ss;
   wire diag, rdy, last, vld, enp, crst;
   wire [19:0] frame;
   wire [7:0] data, idx, in_len, out_len;
   integer failures = 0, checks = 0, i, k, seed;
   sdse_encoder dut_u (.CORE_CLK(clk), .RST(rst), .FIRST_SENSOR_CIRCUIT(c1),
      .SECOND_SENSOR_CIRCUIT(c2), .FIRST_OUTPUT_RELAY(k1), .SECOND_OUTPUT_RELAY(k2),
      .START_ACK_REQ(ack), .ERR_SYSTEM(errs[6]), .ERR_INPUT(errs[5]),
      .ERR_LINK_UV(errs[4]), .ERR_RELAY_UV(errs[3]), .ERR_COMM(errs[2]),
      .ERR_PARAM(errs[1]), .ERR_DIAG(errs[0]), .SWITCH_CLOSED(sw_cl),
      .SWITCH_STATUS(st_w[239:0]), .CHAIN_COUNT(cc), .DIAGNOSTIC_SIGNAL_OUTPUT(diag),
      .FRAME_STATUS(frame), .CYCLE_START(cs), .PD_DATA(data), .PD_INDEX(idx), .PD_LAST(last),
      .PD_VALID(vld), .PD_READY(rdy), .PD_IN_LEN(in_len), .PD_OUT_LEN(out_len),
      .OUT_BYTE(ob), .ENABLE_PATHS(enp), .CHAIN_RESET(crst));
   sdse_link_master lm_u (.CORE_CLK(clk), .RST(rst), .PD_DATA(data), .PD_LAST(last),
      .PD_VALID(vld), .PD_READY(rdy), .stall(stall), .clear(clear));
   initial begin
      forever #10 clk = ~clk;
   end
   // largest pending code wins, zero when nothing pends
   function [3:0] code_of(input [6:0] e);
      integer b;
      begin
         code_of = 4'h0;
         for (b = 0; b < 7; b = b + 1) if (e[b]) code_of = 4'(b + 1);
      end
   endfunction
   task check(input ok, input [95:0] msg);
      begin
         checks = checks + 1;
         if (!ok) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t %0s", $time, msg);
         end
      end
   endtask
   task print_verdict;
      begin
         if (failures == 0 && checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // watchdog: tests need about 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      failures = failures + 1;
      print_verdict;
   end
   initial begin
      seed = $urandom(32'h7C21);
      @(posedge clk);
      @(negedge clk);
      check(diag === 1'b1 && vld === 1'b0 && in_len === 8'h06, "reset values");
      @(posedge clk);
      rst <= 1'b0;
      // first eight passes walk every code alone, the rest are random
      for (i = 0; i < 24; i = i + 1) begin
         @(posedge clk);
         {c1, c2, k1, k2, ack} <= 5'($urandom);
         errs <= (i < 8) ? 7'((8'h01 << i) >> 1) : 7'($urandom);
         sw_cl <= 16'($urandom);
         cc <= (i < 9) ? CORNER[8*i+:8] : 8'($urandom_range(30, 0));
         ob <= 8'($urandom);
         stall <= i[0];
         for (k = 0; k < 8; k = k + 1) st_w[32*k+:32] <= $urandom;
         repeat (30) @(posedge clk);
         @(negedge clk);
         check(frame === {sw_cl, ack, k1 & k2, c2, c1}, "frame");
         for (k = 0; k < 20; k = k + 1) begin
            s[k] = diag;
            @(negedge clk);
         end
         hit = 1'b0;
         fexp = ~{sw_cl, ack, k1 & k2, c2, c1};
         // any rotation of the sampled levels may line up with the frame start
         for (k = 0; k < 20; k = k + 1) begin
            ss = {s, s} >> k;
            if (ss[19:0] === fexp) hit = 1'b1;
         end
         check(hit, "serial frame");
         @(posedge clk);
         cs <= 1'b1;
         clear <= 1'b1;
         @(posedge clk);
         cs <= 1'b0;
         clear <= 1'b0;
         // let the clear land before polling, else the old done flag is seen
         @(negedge clk);
         for (k = 0; k < 400 && lm_u.rx_done !== 1'b1; k = k + 1) @(negedge clk);
         len = cc <= 8'h05 ? 8'h06 : cc <= 8'h0A ? 8'h0B : cc <= 8'h14 ? 8'h15 : 8'h1F;
         check(lm_u.rx_done === 1'b1 && lm_u.rx_cnt === len, "length");
         check(lm_u.rx_mem[0] === {code_of(errs), ack, k1 & k2, c2, c1}, "byte0");
         for (k = 1; k < len; k = k + 1) check(lm_u.rx_mem[k] === (st_w[8*(k-1)+:8] & 8'hE7), "switch byte");
      end
      print_verdict;
   end
endmodule // tb_safety_relay_diag_status_encoder
